// >>> include/csf_pkg.sv
// Package for the status flags register: bit positions, addresses, opcodes
package csf_pkg;
	localparam int          CSF_W         = 8;
	localparam int          CSF_AW        = 9;
	localparam int          CSF_FW        = 7;
	// Bit positions inside the status register
	localparam int          CSF_B_CARRY   = 0;
	localparam int          CSF_B_NIBBLE  = 1;
	localparam int          CSF_B_ZERO    = 2;
	localparam int          CSF_B_SLEEP   = 3;
	localparam int          CSF_B_WDOG    = 4;
	localparam int          CSF_B_BANK_LO = 5;
	localparam int          CSF_B_BANK_HI = 6;
	localparam int          CSF_B_IPAGE   = 7;
	localparam int          CSF_NIB       = 4;
	// Power-up value; the low three flags are unknown, taken as zero
	localparam logic [7:0]  CSF_POR_VAL   = 8'h18;
	// Bank bits cleared by a non power-up reset
	localparam logic [7:0]  CSF_BANK_MASK = 8'he0;
	// Bits that instruction data may never write
	localparam logic [7:0]  CSF_HW_MASK   = 8'h18;
	// Arithmetic flags
	localparam logic [7:0]  CSF_ARI_MASK  = 8'h07;
	// Register offset in bank 0 and its mirrors
	localparam logic [8:0]  CSF_ADDR_B0   = 9'h003;
	localparam logic [8:0]  CSF_ADDR_B1   = 9'h083;
	localparam logic [8:0]  CSF_ADDR_B2   = 9'h103;
	localparam logic [8:0]  CSF_ADDR_B3   = 9'h183;
	localparam logic [7:0]  CSF_ZERO8     = 8'h00;

	typedef enum logic [3:0] {
		CSF_OP_NOP,
		CSF_OP_ADD_WF,
		CSF_OP_ADD_LIT,
		CSF_OP_SUB_LIT,
		CSF_OP_SUB_WF,
		CSF_OP_AND_WF,
		CSF_OP_ROT_R,
		CSF_OP_ROT_L,
		CSF_OP_CLR_F,
		CSF_OP_BIT_CLR,
		CSF_OP_BIT_SET,
		CSF_OP_SWAP,
		CSF_OP_MOV_WF,
		CSF_OP_WDOG_CLR,
		CSF_OP_SLEEP
	} csf_op_t;
endpackage : csf_pkg

// >>> include/csf_alu_if.sv
// Interface carrying operands and flag results between core and ALU
`timescale 1ns/1ps
interface csf_alu_if;
	import csf_pkg::*;
	csf_op_t    op;
	logic [7:0] file_val;
	logic [7:0] w_val;
	logic [7:0] lit;
	logic [2:0] bit_idx;
	logic       carry_in;
	logic [7:0] result;
	logic       zero;
	logic       nibble;
	logic       carry;
	logic       upd_zero;
	logic       upd_nibble;
	logic       upd_carry;
	logic       to_file;

	modport core (output op, file_val, w_val, lit, bit_idx, carry_in,
		input result, zero, nibble, carry, upd_zero, upd_nibble, upd_carry, to_file);
	modport alu  (input op, file_val, w_val, lit, bit_idx, carry_in,
		output result, zero, nibble, carry, upd_zero, upd_nibble, upd_carry, to_file);
endinterface : csf_alu_if

// >>> rtl/csf_flags_alu.sv
// Combinational ALU producing the result and the arithmetic flags
`timescale 1ns/1ps
module csf_flags_alu (
	csf_alu_if.alu a
);
	import csf_pkg::*;

	logic [8:0] sum;
	logic [4:0] nsum;
	logic [7:0] addend;
	logic [7:0] base;
	logic       cin;

	// Subtraction adds the inverted subtrahend plus one, so carry means no borrow
	always_comb begin
		base   = a.file_val;
		addend = a.w_val;
		cin    = 1'b0;
		case (a.op)
			CSF_OP_ADD_LIT: base = a.lit;
			CSF_OP_SUB_LIT: begin
				base   = a.lit;
				addend = ~a.w_val;
				cin    = 1'b1;
			end
			CSF_OP_SUB_WF: begin
				addend = ~a.w_val;
				cin    = 1'b1;
			end
			default: ;
		endcase
		sum  = {1'b0, base} + {1'b0, addend} + {8'h00, cin};
		nsum = {1'b0, base[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
	end

	// Result and which flags each operation touches
	always_comb begin
		a.result     = sum[7:0];
		a.carry      = sum[CSF_W];
		a.nibble     = nsum[CSF_NIB];
		a.upd_zero   = 1'b0;
		a.upd_nibble = 1'b0;
		a.upd_carry  = 1'b0;
		a.to_file    = 1'b1;
		case (a.op)
			CSF_OP_ADD_WF, CSF_OP_ADD_LIT, CSF_OP_SUB_LIT, CSF_OP_SUB_WF: begin
				a.upd_zero   = 1'b1;
				a.upd_nibble = 1'b1;
				a.upd_carry  = 1'b1;
			end
			CSF_OP_AND_WF: begin
				a.result   = a.file_val & a.w_val;
				a.upd_zero = 1'b1;
			end
			CSF_OP_ROT_R: begin
				a.result    = {a.carry_in, a.file_val[7:1]};
				a.carry     = a.file_val[0];
				a.upd_carry = 1'b1;
			end
			CSF_OP_ROT_L: begin
				a.result    = {a.file_val[6:0], a.carry_in};
				a.carry     = a.file_val[7];
				a.upd_carry = 1'b1;
			end
			CSF_OP_CLR_F: begin
				a.result   = CSF_ZERO8;
				a.upd_zero = 1'b1;
			end
			// No flag effects for these, so they edit the status safely
			CSF_OP_BIT_CLR: a.result = a.file_val & ~(8'h01 << a.bit_idx);
			CSF_OP_BIT_SET: a.result = a.file_val | (8'h01 << a.bit_idx);
			CSF_OP_SWAP:    a.result = {a.file_val[3:0], a.file_val[7:4]};
			CSF_OP_MOV_WF:  a.result = a.w_val;
			default:        a.to_file = 1'b0;
		endcase
		a.zero = (a.result == CSF_ZERO8);
	end
endmodule : csf_flags_alu

// >>> rtl/csf_status_reg.sv
// Processor status register with its flag logic and bank address decode
`timescale 1ns/1ps
module csf_status_reg (
	input  wire logic            clk,
	input  wire logic            resetn,
	input  wire logic            op_valid,
	input  wire csf_pkg::csf_op_t op_code,
	input  wire logic [6:0]      op_file_addr,
	input  wire logic            op_dest_file,
	input  wire logic [7:0]      op_literal,
	input  wire logic [2:0]      op_bit_idx,
	input  wire logic [7:0]      file_rd_data,
	input  wire logic [7:0]      w_data,
	input  wire logic [7:0]      indirect_ptr,
	input  wire logic            watchdog_expired,
	input  wire logic            warm_reset,
	output logic [7:0]           status_q,
	output logic [8:0]           direct_addr,
	output logic [8:0]           indirect_addr,
	output logic                 status_hit,
	output logic [7:0]           result_data,
	output logic                 file_wr,
	output logic                 w_wr
);
	import csf_pkg::*;

	typedef struct packed {
		logic [1:0] sync;
	} csf_sync_t;

	typedef struct packed {
		logic [7:0] status;
		logic [7:0] result;
		logic       file_wr;
		logic       w_wr;
	} csf_state_t;

	csf_sync_t  sync_ff;
	csf_sync_t  nxt_sync;
	csf_state_t st_ff;
	csf_state_t nxt_st;
	logic       rst_n;
	logic [7:0] st_view;
	logic [7:0] after_write;
	logic       targets_status;

	csf_alu_if alu_bus ();

	csf_flags_alu u_alu (
		.a (alu_bus.alu)
	);

	// Reset release passes two flops so deassertion is clean for every flop below
	always_comb begin
		nxt_sync.sync = {sync_ff.sync[0], 1'b1};
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync_ff <= '0;
		end else begin
			sync_ff <= nxt_sync;
		end
	end

	assign rst_n = sync_ff.sync[1];

	// Address composition from bank and page bits
	assign st_view        = st_ff.status;
	assign direct_addr    = {st_view[CSF_B_BANK_HI], st_view[CSF_B_BANK_LO], op_file_addr};
	assign indirect_addr  = {st_view[CSF_B_IPAGE], indirect_ptr};
	// Mirrored in every bank, so software never needs to switch bank to reach it
	assign targets_status = (direct_addr == CSF_ADDR_B0) || (direct_addr == CSF_ADDR_B1) ||
	                        (direct_addr == CSF_ADDR_B2) || (direct_addr == CSF_ADDR_B3);
	assign status_hit     = targets_status;

	// Operands to the ALU; the status is read straight from the flops when targeted
	always_comb begin
		alu_bus.op       = op_valid ? op_code : CSF_OP_NOP;
		alu_bus.file_val = targets_status ? st_view : file_rd_data;
		alu_bus.w_val    = w_data;
		alu_bus.lit      = op_literal;
		alu_bus.bit_idx  = op_bit_idx;
		alu_bus.carry_in = st_view[CSF_B_CARRY];
	end

	// Next state of the register and of the result strobes
	always_comb begin
		nxt_st         = st_ff;
		nxt_st.file_wr = 1'b0;
		nxt_st.w_wr    = 1'b0;
		after_write    = st_view;
		if (op_valid && alu_bus.to_file) begin
			nxt_st.result = alu_bus.result;
			// Literal ops have no file operand, so their result always lands in W
			if ((op_dest_file && op_code != CSF_OP_ADD_LIT &&
			     op_code != CSF_OP_SUB_LIT) ||
			    op_code == CSF_OP_CLR_F || op_code == CSF_OP_MOV_WF ||
			    op_code == CSF_OP_BIT_CLR || op_code == CSF_OP_BIT_SET) begin
				// Status is just another file destination, hardware bits masked off
				if (targets_status) begin
					after_write = (alu_bus.result & ~CSF_HW_MASK) |
					              (st_view & CSF_HW_MASK);
					// A flag-setting op keeps its data off all three flags, so
					// the flags that it does not compute stay as they were
					if (alu_bus.upd_zero || alu_bus.upd_nibble || alu_bus.upd_carry) begin
						after_write = (after_write & ~CSF_ARI_MASK) |
						              (st_view & CSF_ARI_MASK);
					end
				end else begin
					nxt_st.file_wr = 1'b1;
				end
			end else begin
				nxt_st.w_wr = 1'b1;
			end
		end
		// Flag logic overrides the data write in each of the low three bits that the op updates
		if (op_valid && alu_bus.upd_zero) begin
			after_write[CSF_B_ZERO] = alu_bus.zero;
		end
		if (op_valid && alu_bus.upd_nibble) begin
			after_write[CSF_B_NIBBLE] = alu_bus.nibble;
		end
		if (op_valid && alu_bus.upd_carry) begin
			after_write[CSF_B_CARRY] = alu_bus.carry;
		end
		// Hardware events on the reset-cause flags
		if (op_valid && op_code == CSF_OP_WDOG_CLR) begin
			after_write[CSF_B_WDOG]  = 1'b1;
			after_write[CSF_B_SLEEP] = 1'b1;
		end
		if (op_valid && op_code == CSF_OP_SLEEP) begin
			after_write[CSF_B_WDOG]  = 1'b1;
			after_write[CSF_B_SLEEP] = 1'b0;
		end
		// Expiry wins over a same-cycle clear so the time-out is never lost
		if (watchdog_expired) begin
			after_write[CSF_B_WDOG] = 1'b0;
		end
		nxt_st.status = after_write;
		// A warm reset clears bank bits and keeps the flags, aborting the instruction
		if (warm_reset) begin
			nxt_st.status  = st_view & ~CSF_BANK_MASK;
			if (watchdog_expired) begin
				nxt_st.status[CSF_B_WDOG] = 1'b0;
			end
			nxt_st.file_wr = 1'b0;
			nxt_st.w_wr    = 1'b0;
		end
	end

	// Power-up value comes from the synchronised reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '{status: CSF_POR_VAL, result: CSF_ZERO8, file_wr: 1'b0, w_wr: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign status_q    = st_ff.status;
	assign result_data = st_ff.result;
	assign file_wr     = st_ff.file_wr;
	assign w_wr        = st_ff.w_wr;

	// Assertions next to the logic they guard
	chk_status_mirror: assert property (@(posedge clk) disable iff (!rst_n)
		status_hit == (op_file_addr == CSF_ADDR_B0[6:0]))
		else $error("status not decoded at a mirrored address");

	chk_direct_bank: assert property (@(posedge clk) disable iff (!rst_n)
		direct_addr[8:7] == status_q[CSF_B_BANK_HI:CSF_B_BANK_LO])
		else $error("direct bank does not follow bank bits");

	chk_indirect_page: assert property (@(posedge clk) disable iff (!rst_n)
		indirect_addr[8] == status_q[CSF_B_IPAGE])
		else $error("indirect page does not follow page bit");

	chk_hw_bits_locked: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_MOV_WF && status_hit && !warm_reset && !watchdog_expired)
		|=> $stable(status_q[CSF_B_WDOG:CSF_B_SLEEP]))
		else $error("instruction data reached reset-cause flags");

	chk_clear_pattern: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_CLR_F && status_hit && !warm_reset && !watchdog_expired)
		|=> (status_q[7:5] == 3'h0) && status_q[CSF_B_ZERO] &&
		    (status_q[4:3] == $past(status_q[4:3])) &&
		    (status_q[1:0] == $past(status_q[1:0])))
		else $error("clear of status left wrong pattern");

	chk_sub_no_borrow: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_SUB_WF && !warm_reset && (file_rd_data >= w_data) &&
		 !status_hit) |=> status_q[CSF_B_CARRY])
		else $error("subtract without borrow left carry clear");

	chk_add_carry: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_ADD_WF && !warm_reset && !status_hit)
		|=> status_q[CSF_B_CARRY] ==
		    (({1'b0, $past(file_rd_data)} + {1'b0, $past(w_data)}) > 9'h0ff))
		else $error("carry does not match add overflow");

	chk_rot_right: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_ROT_R && !warm_reset && !status_hit)
		|=> status_q[CSF_B_CARRY] == $past(file_rd_data[0]))
		else $error("right rotate did not load low bit into carry");

	chk_swap_flags: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_SWAP && !warm_reset && !status_hit)
		|=> $stable(status_q[2:0]))
		else $error("nibble swap altered arithmetic flags");

	chk_sleep_flags: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_SLEEP && !watchdog_expired && !warm_reset)
		|=> status_q[CSF_B_WDOG] && !status_q[CSF_B_SLEEP])
		else $error("sleep did not set time-out and clear sleep flag");

	chk_expiry: assert property (@(posedge clk) disable iff (!rst_n)
		watchdog_expired |=> !status_q[CSF_B_WDOG])
		else $error("watchdog expiry not recorded");

	chk_zero_flag: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_AND_WF && !warm_reset && !status_hit)
		|=> status_q[CSF_B_ZERO] == (($past(file_rd_data) & $past(w_data)) == 8'h00))
		else $error("zero flag wrong after logic op");

	chk_nibble_carry: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_ADD_LIT && !warm_reset)
		|=> status_q[CSF_B_NIBBLE] == (({1'b0, $past(op_literal[3:0])} +
		    {1'b0, $past(w_data[3:0])}) > 5'h0f))
		else $error("nibble carry wrong after literal add");

	chk_sub_twos: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_SUB_LIT && !warm_reset)
		|=> result_data == $past(op_literal) - $past(w_data))
		else $error("literal subtract result wrong");

	chk_flag_override: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_ADD_WF && op_dest_file && status_hit && !warm_reset)
		|=> status_q[CSF_B_ZERO] == (result_data == 8'h00) && !file_wr)
		else $error("flag logic did not override status write");

	chk_rot_left: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_ROT_L && !warm_reset && !status_hit)
		|=> status_q[CSF_B_CARRY] == $past(file_rd_data[7]))
		else $error("left rotate did not load high bit into carry");

	chk_sub_borrow: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && !warm_reset && !status_hit &&
		 ((op_code == CSF_OP_SUB_WF && file_rd_data < w_data) ||
		  (op_code == CSF_OP_SUB_LIT && op_literal < w_data)))
		|=> !status_q[CSF_B_CARRY])
		else $error("subtract with borrow left carry set");

	chk_sub_nibble: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_SUB_WF && !warm_reset && !status_hit &&
		 (file_rd_data[3:0] < w_data[3:0]))
		|=> !status_q[CSF_B_NIBBLE])
		else $error("digit borrow left nibble carry set");

	chk_wdog_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && op_code == CSF_OP_WDOG_CLR && !warm_reset && !watchdog_expired)
		|=> status_q[CSF_B_WDOG] && status_q[CSF_B_SLEEP])
		else $error("watchdog clear did not set both reset-cause flags");

	chk_warm_banks: assert property (@(posedge clk) disable iff (!rst_n)
		warm_reset |=> (status_q[CSF_B_IPAGE:CSF_B_BANK_LO] == 3'h0) && !file_wr && !w_wr)
		else $error("warm reset left bank bits or a write strobe");

	chk_literal_to_w: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && !warm_reset && (op_code == CSF_OP_ADD_LIT || op_code == CSF_OP_SUB_LIT))
		|=> w_wr && !file_wr)
		else $error("literal op result not sent to W");

	chk_status_no_fwr: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && status_hit) |=> !file_wr)
		else $error("file write strobe raised for the status address");

	chk_strobes_excl: assert property (@(posedge clk) disable iff (!rst_n)
		!(file_wr && w_wr))
		else $error("file and W write strobes raised together");

	chk_bits_flags: assert property (@(posedge clk) disable iff (!rst_n)
		(op_valid && !warm_reset && !status_hit && (op_code == CSF_OP_BIT_CLR ||
		 op_code == CSF_OP_BIT_SET || op_code == CSF_OP_MOV_WF))
		|=> $stable(status_q[CSF_B_ZERO:CSF_B_CARRY]))
		else $error("bit or move op altered arithmetic flags");

	chk_idle_hold: assert property (@(posedge clk) disable iff (!rst_n)
		(!op_valid && !warm_reset && !watchdog_expired) |=> $stable(status_q))
		else $error("status changed with no instruction or event");
endmodule : csf_status_reg

// >>> dv/tb_csf_status_reg.sv
// Self-checking testbench for the processor status flags register
`timescale 1ns/1ps
module tb_csf_status_reg;
	import csf_pkg::*;
	logic       clk              = 1'b0;
	logic       resetn           = 1'b0;
	logic       op_valid         = 1'b0;
	csf_op_t    op_code          = CSF_OP_NOP;
	logic [6:0] op_file_addr     = 7'h00;
	logic       op_dest_file     = 1'b0;
	logic [7:0] op_literal       = 8'h00;
	logic [2:0] op_bit_idx       = 3'h0;
	logic [7:0] file_rd_data     = 8'h00;
	logic [7:0] w_data           = 8'h00;
	logic [7:0] indirect_ptr     = 8'ha5;
	logic       watchdog_expired = 1'b0;
	logic       warm_reset       = 1'b0;
	logic [7:0] status_q;
	logic [7:0] result_data;
	logic [8:0] direct_addr;
	logic [8:0] indirect_addr;
	logic       status_hit;
	logic       file_wr;
	logic       w_wr;
	int         err_total        = 0;
	int         n_tests          = 0;

	csf_status_reg dut (.clk(clk), .resetn(resetn), .op_valid(op_valid), .op_code(op_code),
		.op_file_addr(op_file_addr), .op_dest_file(op_dest_file), .op_literal(op_literal),
		.op_bit_idx(op_bit_idx), .file_rd_data(file_rd_data), .w_data(w_data),
		.indirect_ptr(indirect_ptr), .watchdog_expired(watchdog_expired),
		.warm_reset(warm_reset), .status_q(status_q), .direct_addr(direct_addr),
		.indirect_addr(indirect_addr), .status_hit(status_hit), .result_data(result_data),
		.file_wr(file_wr), .w_wr(w_wr));

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	// Compare tasks, one per kind of result
	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte

	task automatic chk_addr(input string what, input logic [8:0] exp, input logic [8:0] got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_addr

	task automatic chk_bit(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_bit

	// One instruction, with optional warm reset / expiry pulses in the same cycle
	// ev[1] is warm reset, ev[0] watchdog expiry; results are settled on return
	task automatic run_op(input csf_op_t code, input logic [6:0] fa, input logic dst,
		input logic [7:0] a, input logic [7:0] wv, input logic [2:0] bi, input logic [1:0] ev);
		@(posedge clk);
		#1;
		op_code          = code;
		op_file_addr     = fa;
		op_dest_file     = dst;
		file_rd_data     = a;
		op_literal       = a;
		w_data           = wv;
		op_bit_idx       = bi;
		warm_reset       = ev[1];
		watchdog_expired = ev[0];
		op_valid         = 1'b1;
		@(posedge clk);
		#1;
		op_valid         = 1'b0;
		warm_reset       = 1'b0;
		watchdog_expired = 1'b0;
	endtask : run_op

	// Bank bits through bit set/clear, mirrored decode, indirect page, swap
	task automatic t_bank();
		run_op(CSF_OP_ADD_WF, 7'h20, 1'b0, 8'hff, 8'h01, 3'h0, 2'b00);
		for (int i = 0; i < 4; i++) begin
			run_op(i[0] ? CSF_OP_BIT_SET : CSF_OP_BIT_CLR, 7'h03, 1'b1, 8'h00, 8'h00, 3'h5, 2'b00);
			run_op(i[1] ? CSF_OP_BIT_SET : CSF_OP_BIT_CLR, 7'h03, 1'b1, 8'h00, 8'h00, 3'h6, 2'b00);
			chk_byte("status bank", {1'b0, i[1:0], 5'h1f}, status_q);
			chk_addr("direct addr", {i[1:0], 7'h03}, direct_addr);
			chk_bit("hit mirror", 1'b1, status_hit);
			chk_bit("file_wr status", 1'b0, file_wr);
			@(posedge clk);
			#1;
			op_file_addr = 7'h23;
			#1;
			chk_bit("hit other", 1'b0, status_hit);
		end
		run_op(CSF_OP_BIT_SET, 7'h03, 1'b1, 8'h00, 8'h00, 3'h7, 2'b00);
		chk_addr("indirect hi", 9'h1a5, indirect_addr);
		run_op(CSF_OP_BIT_CLR, 7'h03, 1'b1, 8'h00, 8'h00, 3'h7, 2'b00);
		chk_addr("indirect lo", 9'h0a5, indirect_addr);
		// Swap of 7fh gives f7h, but bits 4:3 stay set
		run_op(CSF_OP_SWAP, 7'h03, 1'b1, 8'h00, 8'h00, 3'h0, 2'b00);
		chk_byte("status swap", 8'hff, status_q);
		$display("test bank done");
	endtask : t_bank

	// Arithmetic, logic and rotate flags against a hand-worked table
	task automatic t_arith();
		csf_op_t    ops [9] = '{CSF_OP_ADD_WF, CSF_OP_ADD_WF, CSF_OP_ADD_LIT, CSF_OP_SUB_WF,
			CSF_OP_SUB_WF, CSF_OP_SUB_LIT, CSF_OP_AND_WF, CSF_OP_ROT_L, CSF_OP_ROT_R};
		logic [7:0] av [9] = '{8'h0f, 8'hff, 8'h88, 8'h05, 8'h03, 8'h10, 8'hf0, 8'h80, 8'h02};
		logic [7:0] wv [9] = '{8'h01, 8'h01, 8'h88, 8'h05, 8'h05, 8'h01, 8'h0f, 8'h00, 8'h00};
		logic [7:0] rv [9] = '{8'h10, 8'h00, 8'h10, 8'h00, 8'hfe, 8'h0f, 8'h00, 8'h01, 8'h81};
		logic [2:0] fv [9] = '{3'b010, 3'b111, 3'b011, 3'b111, 3'b000, 3'b001, 3'b101, 3'b101,
			3'b100};
		for (int i = 0; i < 9; i++) begin
			run_op(ops[i], 7'h20, 1'b0, av[i], wv[i], 3'h0, 2'b00);
			chk_byte("alu result", rv[i], result_data);
			chk_bit("zero", fv[i][2], status_q[CSF_B_ZERO]);
			chk_bit("nibble", fv[i][1], status_q[CSF_B_NIBBLE]);
			chk_bit("carry", fv[i][0], status_q[CSF_B_CARRY]);
			chk_bit("w_wr", 1'b1, w_wr);
		end
		run_op(CSF_OP_ADD_WF, 7'h20, 1'b1, 8'h01, 8'h01, 3'h0, 2'b00);
		chk_bit("file_wr", 1'b1, file_wr);
		// Clearing the only set bit gives zero, yet the zero flag must not move
		run_op(CSF_OP_BIT_CLR, 7'h20, 1'b1, 8'h04, 8'h00, 3'h2, 2'b00);
		chk_byte("bit clear file", 8'h00, result_data);
		chk_byte("flags kept", 8'hf8, status_q);
		chk_bit("file_wr bit op", 1'b1, file_wr);
		$display("test arith done");
	endtask : t_arith

	// Writes aimed at the status itself
	task automatic t_status_dst();
		run_op(CSF_OP_MOV_WF, 7'h03, 1'b1, 8'h00, 8'h00, 3'h0, 2'b00);
		chk_byte("mov 00", 8'h18, status_q);
		run_op(CSF_OP_MOV_WF, 7'h03, 1'b1, 8'h00, 8'h20, 3'h0, 2'b00);
		// 38h + c8h wraps to zero with both carries, bits 7:5 from the sum
		run_op(CSF_OP_ADD_WF, 7'h03, 1'b1, 8'h55, 8'hc8, 3'h0, 2'b00);
		chk_byte("add to status", 8'h1f, status_q);
		chk_bit("no file write", 1'b0, file_wr);
		// Low flags set beforehand, so the clear must be seen to keep them
		run_op(CSF_OP_MOV_WF, 7'h03, 1'b1, 8'h00, 8'he3, 3'h0, 2'b00);
		chk_byte("mov e3", 8'hfb, status_q);
		run_op(CSF_OP_CLR_F, 7'h03, 1'b1, 8'h00, 8'h00, 3'h0, 2'b00);
		chk_byte("clear status", 8'h1f, status_q);
		$display("test status_dst done");
	endtask : t_status_dst

	// Watchdog expiry, sleep, watchdog clear and warm reset
	task automatic t_events();
		run_op(CSF_OP_NOP, 7'h20, 1'b0, 8'h00, 8'h00, 3'h0, 2'b01);
		chk_byte("expiry", 8'h0f, status_q);
		run_op(CSF_OP_SLEEP, 7'h20, 1'b0, 8'h00, 8'h00, 3'h0, 2'b00);
		chk_byte("sleep", 8'h17, status_q);
		run_op(CSF_OP_MOV_WF, 7'h03, 1'b1, 8'h00, 8'hff, 3'h0, 2'b00);
		chk_byte("mov ff", 8'hf7, status_q);
		run_op(CSF_OP_WDOG_CLR, 7'h20, 1'b0, 8'h00, 8'h00, 3'h0, 2'b01);
		chk_byte("clear vs expiry", 8'hef, status_q);
		run_op(CSF_OP_WDOG_CLR, 7'h20, 1'b0, 8'h00, 8'h00, 3'h0, 2'b00);
		chk_byte("wdog clear", 8'hff, status_q);
		// Warm reset drops bits 7:5 and aborts the instruction beside it
		run_op(CSF_OP_ADD_WF, 7'h20, 1'b0, 8'h01, 8'h01, 3'h0, 2'b10);
		chk_byte("warm reset", 8'h1f, status_q);
		chk_bit("aborted", 1'b0, w_wr);
		$display("test events done");
	endtask : t_events

	// Power-up reset in mid-run restores the reset value, then the core runs again
	task automatic t_por();
		@(posedge clk);
		#1;
		resetn = 1'b0;
		#1;
		chk_byte("por status", CSF_POR_VAL, status_q);
		chk_bit("por file_wr", 1'b0, file_wr);
		repeat (2) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (5) @(posedge clk);
		run_op(CSF_OP_SLEEP, 7'h20, 1'b0, 8'h00, 8'h00, 3'h0, 2'b00);
		chk_byte("sleep after por", 8'h10, status_q);
		$display("test por done");
	endtask : t_por

	task automatic close_out();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : close_out

	// Watchdog: whole run needs well under 400 cycles
	initial begin
		repeat (3000) @(posedge clk);
		err_total++;
		$display("BAD timeout reached");
		close_out();
	end

	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		#1;
		resetn = 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk_byte("reset value", CSF_POR_VAL, status_q);
		chk_bit("reset w_wr", 1'b0, w_wr);
		t_bank();
		t_arith();
		t_status_dst();
		t_events();
		t_por();
		close_out();
	end
endmodule : tb_csf_status_reg
